// ### core/asp_consts.svh
// Offsets, field positions, reset values and timing counts of the result port
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// Register byte addresses
`define ASP_REG_CTRL 4'h0
`define ASP_REG_STATUS 4'h4
`define ASP_REG_FRAME 4'h8
// Control fields and reset value
`define ASP_CTRL_CLKSRC 0
`define ASP_CTRL_RST 32'h0000_0000
// Frame layout
`define ASP_FRAME_BITS 32
`define ASP_FRAME_PEND 31
`define ASP_FRAME_FILL 30
`define ASP_FRAME_POL 29
`define ASP_RES_BITS 24
`define ASP_SUB_BITS 5
`define ASP_LAST_FALL 5'h1f
// Timing: conversion time in ns, clock rate in MHz
`define ASP_CONV_TIME_NS 1137000
`define ASP_CLK_MHZ 25
`define ASP_CONV_CYC ((`ASP_CONV_TIME_NS * `ASP_CLK_MHZ + 999) / 1000)
`define ASP_SCLK_HALF 4

`endif

// ### core/asp_pkg.sv
// Types shared by the result port modules
package asp_pkg;
	// Operating cycle of the converter
	typedef enum logic [1:0] {
		ASP_CONV,
		ASP_SLEEP,
		ASP_DOUT
	} asp_state_t;

	// One finished conversion from the modulator
	typedef struct packed {
		logic over;          // Input above positive full scale
		logic under;         // Input below negative full scale
		logic [28:0] value;  // Two's complement, 24 result + 5 sub bits
	} asp_sample_t;
endpackage

// ### core/asp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module asp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1 // Reset level of each bit: its pin's idle level
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta; // First stage, read only by the second

	if (W < 1) begin : g_bad
		$error("asp_sync: W must be at least 1");
	end

	// Both stages reset to the idle levels, so no false edge follows reset
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta <= INIT;
			q_o <= INIT;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule

// ### core/asp_sclk_gen.sv
// Internal serial clock divider with edge pulses
`timescale 1ns/10ps
module asp_sclk_gen #(
	parameter int HALF = 4
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	output logic sclk_o,
	output logic rise_o,
	output logic fall_o
);
	localparam int CW = $clog2(HALF) + 1;
	logic [CW-1:0] cnt; // Cycles within a half period
	logic tick;         // One-cycle enable at each half period

	if (HALF < 2) begin : g_bad
		$error("asp_sclk_gen: HALF must be at least 2");
	end

	assign tick = run_i && (cnt == CW'(HALF - 1));
	assign rise_o = tick && !sclk_o;
	assign fall_o = tick && sclk_o;

	// Divider counter; restarts while stopped
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt <= '0;
		end else if (!run_i || tick) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	// Clock level; parks low at once when stopped
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sclk_o <= 1'b0;
		end else if (tick) begin
			sclk_o <= !sclk_o;
		end else if (!run_i) begin
			sclk_o <= 1'b0;
		end
	end
endmodule

// ### core/asp_core.sv
// Serial result port of the converter: cycle control, framing and registers
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "asp_consts.svh"
module asp_core #(
	parameter int CONV_CYCLES = `ASP_CONV_CYC,
	parameter int SCLK_HALF = `ASP_SCLK_HALF
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire asp_pkg::asp_sample_t sample_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_o,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	output logic conv_busy_o,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o
);
	localparam int CCW = $clog2(CONV_CYCLES + 1);

	if (CONV_CYCLES < 1) begin : g_bad
		$error("asp_core: CONV_CYCLES must be at least 1");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	asp_pkg::asp_state_t state;   // Converter cycle
	logic [CCW-1:0] conv_cnt;     // Cycles spent converting
	logic conv_done;              // Last conversion cycle
	logic [31:0] shreg;           // Frame being shifted out
	logic [31:0] frame_q;         // Last frame captured, for software
	logic [4:0] fall_cnt;         // Falling edges seen in data output
	logic clksrc;                 // High: device drives the serial clock
	logic cs_s;                   // Synchronised chip select, active low
	logic sck_s;                  // Synchronised external serial clock
	logic cs_d;                   // Chip select one cycle back
	logic sck_d;                  // External clock one cycle back
	logic cs_rise;                // Chip select released
	logic ext_rise, ext_fall;     // External clock edges
	logic gen_rise, gen_fall;     // Internal clock edges
	logic gen_run;                // Divider may run
	logic sck_rise, sck_fall;     // Edges of the selected clock
	logic gen_sclk;               // Internal clock level

	// ----------------------------------------------------------------
	// Frame assembly
	// ----------------------------------------------------------------
	// Out-of-range inputs are clamped one step past full scale
	function automatic logic [31:0] frame_of(input asp_pkg::asp_sample_t s);
		logic [29:0] body;
		body = {!s.value[28], s.value};
		if (s.over) begin
			body = {2'b11, 28'h000_0000};
		end else if (s.under) begin
			body = {2'b00, 28'hfff_ffff};
		end
		// Pending flag is low once done; filler always low
		return {1'b0, 1'b0, body};
	endfunction

	// ----------------------------------------------------------------
	// Pin inputs and edge detection
	// ----------------------------------------------------------------
	// Each stage resets to its pin's idle level: select high, clock low
	asp_sync #(.W(2), .INIT(2'b10)) u_sync (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i({cs_n_i, sclk_i}),
		.q_o({cs_s, sck_s})
	);

	// Previous levels for edge finding
	// Reset values equal the idle pins, so no false edge follows reset
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cs_d <= 1'b1;
			sck_d <= 1'b0;
		end else begin
			cs_d <= cs_s;
			sck_d <= sck_s;
		end
	end

	assign cs_rise = cs_s && !cs_d;
	assign ext_rise = sck_s && !sck_d;
	assign ext_fall = !sck_s && sck_d;

	// Divider only while selected and a result is waiting or leaving
	assign gen_run = clksrc && !cs_s && (state != asp_pkg::ASP_CONV);

	asp_sclk_gen #(.HALF(SCLK_HALF)) u_gen (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.run_i(gen_run),
		.sclk_o(gen_sclk),
		.rise_o(gen_rise),
		.fall_o(gen_fall)
	);

	// Clock source picks whose edges count
	assign sck_rise = clksrc ? gen_rise : ext_rise;
	assign sck_fall = clksrc ? gen_fall : ext_fall;
	assign sclk_o = gen_sclk;
	assign sclk_oe_o = clksrc;

	// ----------------------------------------------------------------
	// Conversion cycle
	// ----------------------------------------------------------------
	assign conv_done = (state == asp_pkg::ASP_CONV) && (conv_cnt == CCW'(CONV_CYCLES - 1));

	// Conversion timer; cleared whenever not converting
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			conv_cnt <= '0;
		end else if (state != asp_pkg::ASP_CONV || conv_done) begin
			conv_cnt <= '0;
		end else begin
			conv_cnt <= conv_cnt + 1'b1;
		end
	end

	// State walk: convert, sleep, output, convert again
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= asp_pkg::ASP_CONV;
		end else begin
			unique case (state)
				asp_pkg::ASP_CONV: begin
					if (conv_done) begin
						// Result ready: hold it until the host asks
						state <= asp_pkg::ASP_SLEEP;
					end
				end
				asp_pkg::ASP_SLEEP: begin
					// Result held until a rising edge with select low
					if (sck_rise && !cs_s) begin
						state <= asp_pkg::ASP_DOUT;
					end
				end
				asp_pkg::ASP_DOUT: begin
					if (cs_rise) begin
						// Release by the host cuts the frame short
						state <= asp_pkg::ASP_CONV;
					end else if (sck_fall && fall_cnt == `ASP_LAST_FALL) begin
						// Last bit has left; the pin turns to pending
						state <= asp_pkg::ASP_CONV;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Shift register and bit count
	// ----------------------------------------------------------------
	// Loaded at completion, moved only on falling edges
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			shreg <= '0;
		end else if (conv_done) begin
			shreg <= frame_of(sample_i);
		end else if (state == asp_pkg::ASP_DOUT && sck_fall) begin
			shreg <= {shreg[30:0], 1'b0};
		end
	end

	// Counts falling edges of the frame
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fall_cnt <= '0;
		end else if (state != asp_pkg::ASP_DOUT) begin
			fall_cnt <= '0;
		end else if (sck_fall) begin
			fall_cnt <= fall_cnt + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	// Outside output the pin shows the pending flag live
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			serial_out_o <= 1'b1;
			serial_out_oe_o <= 1'b0;
			conv_busy_o <= 1'b1;
		end else begin
			serial_out_oe_o <= !cs_s;
			conv_busy_o <= (state == asp_pkg::ASP_CONV);
			unique case (state)
				asp_pkg::ASP_CONV: serial_out_o <= 1'b1;
				asp_pkg::ASP_SLEEP: serial_out_o <= 1'b0;
				asp_pkg::ASP_DOUT: serial_out_o <= shreg[31];
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	// Control register: clock source select
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clksrc <= 1'(`ASP_CTRL_RST);
		end else if (reg_wr_i && reg_addr_i == `ASP_REG_CTRL) begin
			clksrc <= reg_wdata_i[`ASP_CTRL_CLKSRC];
		end
	end

	// Copy of the last frame for software; survives the shift-out
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_q <= '0;
		end else if (conv_done) begin
			frame_q <= frame_of(sample_i);
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			// Status packs bit count, select and state
			unique case (reg_addr_i)
				`ASP_REG_CTRL: reg_rdata_o <= {31'h0, clksrc};
				`ASP_REG_STATUS: reg_rdata_o <= {24'h0, fall_cnt, !cs_s, state};
				`ASP_REG_FRAME: reg_rdata_o <= frame_q;
				default: reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_frame_end: assert property (
		state == asp_pkg::ASP_DOUT && !cs_rise && sck_fall && fall_cnt == 5'h1f
		|=> state == asp_pkg::ASP_CONV ##1 serial_out_o)
		else $error("frame did not end at 32nd fall");
	a_filler_low: assert property (
		conv_done |=> shreg[31:30] == 2'b00)
		else $error("status bits wrong at load");
	a_over_clamp: assert property (
		conv_done && sample_i.over |=> shreg[29:0] == {2'b11, 28'h0})
		else $error("over-range code wrong");
	a_under_clamp: assert property (
		conv_done && !sample_i.over && sample_i.under |=> shreg[29:0] == {2'b00, 28'hfffffff})
		else $error("under-range code wrong");
	a_sign_body: assert property (
		conv_done && !sample_i.over && !sample_i.under
		|=> shreg[29:0] == {!$past(sample_i.value[28]), $past(sample_i.value)})
		else $error("in-range code wrong");
	a_hiz_cs: assert property (
		cs_s |=> !serial_out_oe_o)
		else $error("output driven with select high");
	a_eoc_live: assert property (
		state == asp_pkg::ASP_CONV && !cs_s |=> serial_out_o && serial_out_oe_o)
		else $error("pending flag not shown");
	a_sleep_hold: assert property (
		state == asp_pkg::ASP_SLEEP && !(sck_rise && !cs_s) |=> state == asp_pkg::ASP_SLEEP)
		else $error("sleep left without rising edge");
	a_shift_fall: assert property (
		state == asp_pkg::ASP_DOUT && !sck_fall |=> $stable(shreg))
		else $error("shift without falling edge");
	a_abort_cs: assert property (
		state == asp_pkg::ASP_DOUT && cs_rise |=> state == asp_pkg::ASP_CONV ##1 conv_busy_o)
		else $error("abort did not restart");
	a_busy_state: assert property (
		state != asp_pkg::ASP_CONV ##1 state != asp_pkg::ASP_CONV |-> !conv_busy_o)
		else $error("busy high outside conversion");
	a_clk_drive: assert property (
		!clksrc |-> !sclk_oe_o && (sck_rise == ext_rise))
		else $error("clock source wrong");
	a_wake_rise: assert property (
		state == asp_pkg::ASP_SLEEP && sck_rise && !cs_s |=> state == asp_pkg::ASP_DOUT)
		else $error("sleep not left on rising edge");
	a_bit_update: assert property (
		state == asp_pkg::ASP_DOUT && !cs_rise && sck_fall && fall_cnt != 5'h1f
		|=> ##1 serial_out_o == $past(shreg[31]))
		else $error("output bit not updated after fall");
	a_done_sleep: assert property (
		conv_done |=> state == asp_pkg::ASP_SLEEP ##1 !serial_out_o && !conv_busy_o)
		else $error("completion not shown");
	a_gen_park: assert property (
		clksrc && state == asp_pkg::ASP_CONV |=> !sclk_o)
		else $error("device clock ran in conversion");

	c_full_read: cover property (state == asp_pkg::ASP_DOUT && sck_fall && fall_cnt == 5'h1f);
	c_abort: cover property (state == asp_pkg::ASP_DOUT && cs_rise);
	c_internal: cover property (clksrc && gen_rise && state == asp_pkg::ASP_SLEEP);
	c_over: cover property (conv_done && sample_i.over);
	c_ext_wake: cover property (!clksrc && state == asp_pkg::ASP_SLEEP && sck_rise && !cs_s);
endmodule

// ### tb/asp_host_model.sv
// Host side of the result port: chip select, serial clock and bit capture
`timescale 1ns/10ps
module asp_host_model (
	input wire logic sys_clk_i,
	input wire logic sdo_i,
	input wire logic sclk_pin_i,
	output logic cs_n_o,
	output logic sclk_o
);
	// Idle host: deselected, clock parked low between frames
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
	end
	// Lower select just after a system clock edge
	task automatic select();
		@(posedge sys_clk_i);
		cs_n_o <= 1'b0;
	endtask
	// Raising select ends a read early
	task automatic deselect();
		@(posedge sys_clk_i);
		cs_n_o <= 1'b1;
	endtask
	// Clock out n bits; in internal mode follow the device's own clock
	task automatic read_frame(input int n, input bit int_clk, output logic [31:0] f);
		f = 32'h0;
		select();
		if (!int_clk) begin
			repeat (8) @(posedge sys_clk_i);
		end
		for (int i = 0; i < n; i++) begin
			if (int_clk) begin
				@(posedge sclk_pin_i);
			end else begin
				// Four cycles high and four low make the 320 ns link clock
				sclk_o <= 1'b1;
				repeat (3) @(posedge sys_clk_i);
				// Device output lags each fall by its synchroniser, so latch late in the high phase
				@(negedge sys_clk_i);
			end
			f[31-i] = sdo_i;
			if (!int_clk) begin
				@(posedge sys_clk_i);
				sclk_o <= 1'b0;
				repeat (4) @(posedge sys_clk_i);
			end
		end
		// The 32nd fall ends the frame in internal mode too
		if (int_clk && n == 32) begin
			@(negedge sclk_pin_i);
		end
	endtask
endmodule

// ### tb/asp_core_tb_top.sv
// Self-checking bench: host model reads frames, bench model predicts them
`timescale 1ns/10ps
`include "asp_consts.svh"
module asp_core_tb_top;
	// ----------------------------------------
	// Signals and bench state
	// ----------------------------------------
	localparam int CONV = 60; // Short conversion keeps the run brief
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	asp_pkg::asp_sample_t sample;
	logic host_sclk, cs_n, sclk_o, sclk_oe, serial_out, sdo_oe, busy;
	logic sdo_hold = 1'b0; // Last level driven on the data line
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, got;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] exp_q[$]; // Expected frames, oldest first
	logic [30:0] tbl[5] = '{31'h0, 31'h1fff_ffff, 31'h4000_0000, 31'h2000_0000, 31'h6000_0000};
	int n_errors = 0;
	int samples_checked = 0;
	int seed = 11;
	int cyc = 0;
	// Shared pins; a released data line shows the inverse of its last level
	wire sclk_pin = sclk_oe ? sclk_o : host_sclk;
	wire sdo_pin = sdo_oe ? serial_out : ~sdo_hold;

	asp_core #(.CONV_CYCLES(CONV), .SCLK_HALF(4)) dut_u (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.sample_i(sample),
		.cs_n_i(cs_n),
		.sclk_i(sclk_pin),
		.sclk_o(sclk_o),
		.sclk_oe_o(sclk_oe),
		.serial_out_o(serial_out),
		.serial_out_oe_o(sdo_oe),
		.conv_busy_o(busy),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_wr_i(wr),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata)
	);
	asp_host_model host_u (
		.sys_clk_i(sys_clk_i),
		.sdo_i(sdo_pin),
		.sclk_pin_i(sclk_pin),
		.cs_n_o(cs_n),
		.sclk_o(host_sclk)
	);
	// 25 MHz system clock
	initial begin
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	// Remember the driven level for the released line
	always @(posedge sys_clk_i) begin
		if (sdo_oe) begin
			sdo_hold <= serial_out;
		end
	end
	// Cut a hang short
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// Model, compares and bus tasks
	// ----------------------------------------
	function automatic logic [31:0] model(input asp_pkg::asp_sample_t s);
		if (s.over) begin
			return 32'h3000_0000;
		end
		if (s.under) begin
			return 32'h0fff_ffff;
		end
		return {2'b00, ~s.value[28], s.value};
	endfunction
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string what);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e, input string what);
		chk_word({31'h0, g}, {31'h0, e}, what);
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk_i);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Bounded wait for the end of a conversion
	task automatic wait_done();
		for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
			@(posedge sys_clk_i);
		end
		#1;
	endtask
	// Read n bits of the waiting frame, loading the next sample meanwhile
	task automatic do_frame(input int n, input bit int_clk, input asp_pkg::asp_sample_t s);
		logic [31:0] f, e, m;
		wait_done();
		chk_bit(busy, 1'b0, "busy in sleep");
		@(posedge sys_clk_i);
		sample <= s;
		exp_q.push_back(model(s));
		host_u.read_frame(n, int_clk, f);
		e = exp_q.pop_front();
		m = ~(32'hffff_ffff >> n);
		chk_word(f & m, e & m, "frame");
		repeat (6) @(posedge sys_clk_i);
		#1;
		if (n == 32) begin
			chk_bit(sdo_pin, 1'b1, "pending after last bit");
		end
		host_u.deselect();
		repeat (6) @(posedge sys_clk_i);
		#1;
		chk_bit(busy, 1'b1, "new conversion");
		chk_bit(sdo_oe, 1'b0, "line released");
	endtask
	task automatic print_verdict();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		asp_pkg::asp_sample_t s;
		sample <= 31'h0123_4567;
		exp_q.push_back(model(31'h0123_4567));
		repeat (16) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge sys_clk_i);
		#1;
		chk_bit(busy, 1'b1, "busy after reset");
		chk_bit(sdo_oe, 1'b0, "released after reset");
		host_u.select();
		repeat (8) @(posedge sys_clk_i);
		#1;
		chk_bit(sdo_pin, 1'b1, "pending live");
		wait_done();
		chk_bit(sdo_pin, 1'b0, "done live");
		reg_rd(`ASP_REG_CTRL, got);
		chk_word(got, `ASP_CTRL_RST, "control reset");
		reg_wr(`ASP_REG_FRAME, 32'hffff_ffff);
		reg_rd(`ASP_REG_FRAME, got);
		chk_word(got, exp_q[0], "frame register");
		reg_rd(4'hc, got);
		chk_word(got, 32'h0, "unmapped read");
		repeat (40) @(posedge sys_clk_i);
		reg_rd(`ASP_REG_STATUS, got);
		chk_word({30'h0, got[1:0]}, 32'h1, "still asleep");
		// Table cases, an aborted read, then the device's own clock
		for (int i = 0; i < 8; i++) begin
			s = (i < 5) ? tbl[i] : 31'($random(seed));
			if (i == 6) begin
				reg_wr(`ASP_REG_CTRL, 32'h1);
				@(posedge sys_clk_i);
				#1;
				chk_bit(sclk_oe, 1'b1, "device drives clock");
			end
			do_frame((i == 5) ? 10 : 32, i >= 6, s);
		end
		print_verdict();
	end
endmodule
